// ==== core/dds_pkg.sv ====
/*
 * Shared constants of the synthesizer control block: serial word layout,
 * control bit positions, reset values and timing counts.
 * Assumes a 25 MHz system clock on both ends.
 */
package dds_pkg;
    localparam int WORD_BITS = 16;
    localparam int ACC_BITS = 28;
    localparam int PHASE_BITS = 12;
    localparam int DAC_BITS = 10;
    // Serial word type field, bits 15 and 14.
    localparam logic [1:0] TYPE_CTRL = 2'h0;
    localparam logic [1:0] TYPE_FREQ_A = 2'h1;
    localparam logic [1:0] TYPE_FREQ_B = 2'h2;
    localparam logic [1:0] TYPE_PHASE = 2'h3;
    localparam int PHASE_TARGET_BIT = 13;
    // Control word bit positions.
    localparam int CB_HALF_SELECT = 12;
    localparam int CB_FREQ_SELECT = 11;
    localparam int CB_PHASE_SELECT = 10;
    localparam int CB_HW_OR_SOFT = 9;
    localparam int CB_RESET = 8;
    localparam int CB_CLOCK_STOP = 7;
    localparam int CB_DAC_DOWN = 6;
    localparam int CB_SQUARE_EN = 5;
    localparam int CB_COMPARATOR = 4;
    localparam int CB_MSB_FULL = 3;
    localparam int CB_WAVE_MODE = 1;
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    localparam logic [9:0] DAC_MIDSCALE = 10'h0200;
    // Cycles from reset release to the first waveform sample.
    localparam logic [2:0] RELEASE_CYCLES = 3'h7;
    // Link clock timing: the host makes a 320 ns serial clock.
    localparam int SYS_CLK_NS = 40;
    localparam int SCLK_PERIOD_NS = 320;
    localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);
    localparam logic [1:0] SCLK_HALF_LAST = 2'(SCLK_HALF_CYCLES - 1);
endpackage : dds_pkg

// ==== core/dds_link_if.sv ====
/*
 * Pin bundle between the host controller and the synthesizer.
 * Assumes the host drives every pin; all lines are one-way.
 */
`timescale 1ns/100ps
interface dds_link_if;
    logic sclk;
    logic sdata;
    logic frame_sync_n;
    logic reset_pin;
    logic sleep_pin;
    logic freq_reg_select_pin;
    logic phase_reg_select_pin;

    modport host (
        output sclk,
        output sdata,
        output frame_sync_n,
        output reset_pin,
        output sleep_pin,
        output freq_reg_select_pin,
        output phase_reg_select_pin
    );
    modport device (
        input sclk,
        input sdata,
        input frame_sync_n,
        input reset_pin,
        input sleep_pin,
        input freq_reg_select_pin,
        input phase_reg_select_pin
    );
endinterface : dds_link_if

// ==== core/sync_two_flop.sv ====
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/100ps
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // The first stage feeds the second stage and nothing else.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule : sync_two_flop

// ==== core/dds_device.sv ====
/*
 * Synthesizer end: serial word decoder, phase and frequency registers,
 * reset and sleep control, phase accumulator, waveform shaping and the
 * square-wave output pin.
 * Assumes the host keeps the framing and pin rules; all link pins are
 * asynchronous and pass a two flip-flop synchroniser first.
 */
`timescale 1ns/100ps
module dds_device (
    input wire logic sys_clk,
    input wire logic arst_n,
    dds_link_if.device link,
    input wire logic comparator_in,
    output logic [9:0] dac_code,
    output logic dac_power_down,
    output logic square_out,
    output logic square_out_enable
);
    typedef struct packed {
        logic sclk_prev;
        logic [15:0] shift;
        logic [4:0] bit_count;
        logic [13:0] ctrl;
        logic [27:0] freq_a;
        logic [27:0] freq_b;
        logic [11:0] phase_offset_a;
        logic [11:0] phase_offset_b;
        logic [27:0] acc;
        logic [11:0] phase;
        logic reset_hold;
        logic sleep_hold;
        logic [2:0] release_count;
        logic msb_prev;
        logic msb_half;
        logic [9:0] dac_code;
        logic dac_power_down;
        logic square_out;
        logic square_out_enable;
    } dev_state_t;

    dev_state_t r;
    dev_state_t next_r;
    logic [6:0] pins_s;
    logic sclk_s, sdata_s, frame_n_s, reset_s, sleep_s, fsel_s, psel_s;
    logic cmp_s;
    logic hw_or_soft_control_select;
    logic core_reset;
    logic core_clock_stop;
    logic run;
    logic [15:0] word;
    logic [11:0] offset;
    logic [9:0] wave;
    logic [10:0] fold;
    logic [21:0] prod;
    logic [8:0] mag;

    ////////////////////////////////////////////////////////////////////////
    // Every pin from the host and the comparator crosses two flip-flops.
    sync_two_flop #(.WIDTH(8)) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .async_in({comparator_in, link.sclk, link.sdata, link.frame_sync_n,
                   link.reset_pin, link.sleep_pin, link.freq_reg_select_pin,
                   link.phase_reg_select_pin}),
        .sync_out({cmp_s, pins_s})
    );
    assign {sclk_s, sdata_s, frame_n_s, reset_s, sleep_s, fsel_s, psel_s} = pins_s;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode, shared by the reset, sleep and register selection logic.
    assign hw_or_soft_control_select = r.ctrl[dds_pkg::CB_HW_OR_SOFT];
    // A rising pin acts on the cycle it is seen; its fall waits one more edge.
    assign core_reset = hw_or_soft_control_select ? (reset_s | r.reset_hold)
                                                  : r.ctrl[dds_pkg::CB_RESET];
    assign core_clock_stop = !hw_or_soft_control_select
                             && r.ctrl[dds_pkg::CB_CLOCK_STOP];
    assign run = !core_reset && !core_clock_stop;
    assign word = {r.shift[14:0], sdata_s};

    // Offset selection stays live while the clock is stopped.
    always_comb begin
        if (hw_or_soft_control_select ? psel_s : r.ctrl[dds_pkg::CB_PHASE_SELECT]) begin
            offset = r.phase_offset_b;
        end else begin
            offset = r.phase_offset_a;
        end
    end

    // Sine by a half-wave parabola: cheaper than a stored table, a few
    // percent of harmonic error is the price.
    always_comb begin
        fold = r.phase[10:0];
        prod = 22'(fold) * 22'(12'h800 - {1'b0, fold});
        mag = (prod[21:11] > 11'h1FF) ? 9'h1FF : prod[19:11];
        if (r.ctrl[dds_pkg::CB_WAVE_MODE]) begin
            // Fold the top bit so the ramp rises then falls.
            wave = r.phase[11] ? ~r.phase[10:1] : r.phase[10:1];
        end else if (r.phase[11]) begin
            wave = dds_pkg::DAC_MIDSCALE - 10'(mag);
        end else begin
            wave = dds_pkg::DAC_MIDSCALE + 10'(mag);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic of the whole end.
    always_comb begin
        next_r = r;
        next_r.sclk_prev = sclk_s;
        next_r.reset_hold = reset_s;
        next_r.sleep_hold = sleep_s;

        // Serial capture on sampled falling edges while the frame is low.
        if (frame_n_s) begin
            next_r.bit_count = 5'h00;
        end else if (r.sclk_prev && !sclk_s && r.bit_count != 5'(dds_pkg::WORD_BITS)) begin
            next_r.shift = word;
            next_r.bit_count = r.bit_count + 5'h01;
            if (r.bit_count == 5'(dds_pkg::WORD_BITS - 1)) begin
                // Decode is independent of the clock stop.
                case (word[15:14])
                    dds_pkg::TYPE_CTRL: begin
                        next_r.ctrl = word[13:0];
                    end
                    dds_pkg::TYPE_FREQ_A: begin
                        if (r.ctrl[dds_pkg::CB_HALF_SELECT]) begin
                            next_r.freq_a[27:14] = word[13:0];
                        end else begin
                            next_r.freq_a[13:0] = word[13:0];
                        end
                    end
                    dds_pkg::TYPE_FREQ_B: begin
                        if (r.ctrl[dds_pkg::CB_HALF_SELECT]) begin
                            next_r.freq_b[27:14] = word[13:0];
                        end else begin
                            next_r.freq_b[13:0] = word[13:0];
                        end
                    end
                    default: begin
                        // Bit 12 is a don't-care in a phase load.
                        if (word[dds_pkg::PHASE_TARGET_BIT]) begin
                            next_r.phase_offset_b = word[11:0];
                        end else begin
                            next_r.phase_offset_a = word[11:0];
                        end
                    end
                endcase
            end
        end

        // Datapath: cleared by reset, frozen while the core clock is stopped.
        if (core_reset) begin
            next_r.acc = '0;
            next_r.phase = '0;
            next_r.release_count = 3'h0;
            next_r.dac_code = dds_pkg::DAC_MIDSCALE;
            next_r.msb_prev = 1'b0;
            next_r.msb_half = 1'b0;
        end else if (run) begin
            if (hw_or_soft_control_select ? fsel_s : r.ctrl[dds_pkg::CB_FREQ_SELECT]) begin
                next_r.acc = r.acc + r.freq_b;
            end else begin
                next_r.acc = r.acc + r.freq_a;
            end
            next_r.phase = r.acc[27:16] + offset;
            if (r.release_count != dds_pkg::RELEASE_CYCLES) begin
                next_r.release_count = r.release_count + 3'h1;
            end
            // Pending register changes flow through here on restart.
            if (r.release_count >= dds_pkg::RELEASE_CYCLES - 3'h1) begin
                next_r.dac_code = wave;
            end
            next_r.msb_prev = r.phase[11];
            if (r.phase[11] && !r.msb_prev) begin
                next_r.msb_half = !r.msb_half;
            end
        end
        // Otherwise everything holds, the DAC code included.

        // DAC power: pin in pin mode, control bit in software mode.
        if (hw_or_soft_control_select) begin
            next_r.dac_power_down = sleep_s | r.sleep_hold;
        end else begin
            next_r.dac_power_down = r.ctrl[dds_pkg::CB_DAC_DOWN];
        end

        // Square-wave pin source and enable.
        next_r.square_out_enable = r.ctrl[dds_pkg::CB_SQUARE_EN];
        if (!r.ctrl[dds_pkg::CB_SQUARE_EN]) begin
            next_r.square_out = 1'b0;
        end else if (r.ctrl[dds_pkg::CB_COMPARATOR]) begin
            next_r.square_out = cmp_s;
        end else if (r.ctrl[dds_pkg::CB_MSB_FULL]) begin
            next_r.square_out = r.phase[11];
        end else begin
            next_r.square_out = r.msb_half;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; registers keep no reset value but a defined one.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{dac_code: dds_pkg::DAC_MIDSCALE, ctrl: dds_pkg::CTRL_RESET,
                   sclk_prev: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign dac_code = r.dac_code;
    assign dac_power_down = r.dac_power_down;
    assign square_out = r.square_out;
    assign square_out_enable = r.square_out_enable;
endmodule : dds_device

// ==== core/dds_host.sv ====
/*
 * Host end: shifts 16-bit words out over the three-wire link with a
 * divided serial clock and drives the reset, sleep and select pins.
 * Assumes the user keeps the mode, sleep and power-up reset rules.
 */
`timescale 1ns/100ps
module dds_host (
    input wire logic sys_clk,
    input wire logic arst_n,
    dds_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    output logic cmd_ready,
    input wire logic reset_request,
    input wire logic sleep_request,
    input wire logic freq_select,
    input wire logic phase_select
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BITS = 3'b010,
        ST_END = 3'b100
    } host_st_t;

    typedef struct packed {
        host_st_t st;
        logic [1:0] div;
        logic [15:0] word;
        logic [3:0] bit_index;
        logic sclk;
        logic frame_sync_n;
        logic reset_pin;
        logic sleep_pin;
        logic fsel;
        logic psel;
        logic ready;
        logic sdata;
    } host_state_t;

    host_state_t r;
    host_state_t next_r;
    logic tick;

    // Half-period enable of the serial clock.
    assign tick = (r.div == dds_pkg::SCLK_HALF_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Word sequencer: data changes on the rising edge, the device takes it
    // on the falling edge, sixteen falling edges per frame.
    always_comb begin
        next_r = r;
        next_r.div = tick ? 2'h0 : r.div + 2'h1;
        // Pins follow the user; power-up reset is the user's duty.
        next_r.reset_pin = reset_request;
        next_r.sleep_pin = sleep_request;
        next_r.fsel = freq_select;
        next_r.psel = phase_select;
        case (r.st)
            ST_IDLE: begin
                if (cmd_valid) begin
                    next_r.word = cmd_word;
                    next_r.bit_index = 4'hF;
                    next_r.frame_sync_n = 1'b0;
                    next_r.div = 2'h0;
                    next_r.st = ST_BITS;
                end
            end
            ST_BITS: begin
                if (tick) begin
                    next_r.sclk = !r.sclk;
                    if (!r.sclk) begin
                        if (r.bit_index == 4'h0) begin
                            next_r.st = ST_END;
                        end else begin
                            next_r.bit_index = r.bit_index - 4'h1;
                        end
                    end
                end
            end
            default: begin
                if (tick) begin
                    next_r.frame_sync_n = 1'b1;
                    next_r.st = ST_IDLE;
                end
            end
        endcase
        // Ready and data are registered so that no output glitches on a decode.
        next_r.ready = (next_r.st == ST_IDLE);
        next_r.sdata = next_r.word[next_r.bit_index];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{st: ST_IDLE, sclk: 1'b1, frame_sync_n: 1'b1, ready: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign cmd_ready = r.ready;
    assign link.sclk = r.sclk;
    assign link.sdata = r.sdata;
    assign link.frame_sync_n = r.frame_sync_n;
    assign link.reset_pin = r.reset_pin;
    assign link.sleep_pin = r.sleep_pin;
    assign link.freq_reg_select_pin = r.fsel;
    assign link.phase_reg_select_pin = r.psel;
endmodule : dds_host

// ==== test/dds_link_checker.sv ====
/*
 * Concurrent checks on the link between host and synthesizer ends.
 * Assumes the bench wires it to the link and device outputs by name.
 */
`timescale 1ns/100ps
module dds_link_checker (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic frame_sync_n,
    input wire logic reset_pin,
    input wire logic sleep_pin,
    input wire logic comparator_in,
    input wire logic [9:0] dac_code,
    input wire logic dac_power_down,
    input wire logic square_out,
    input wire logic square_out_enable
);
    logic sclk_q;
    logic [15:0] shift;
    logic [4:0] bit_count;
    logic [13:0] ctrl;
    logic [3:0] age;
    logic taken;
    logic age_ok;
    logic [15:0] word;

    ////////////////////////////////////////////////////////////////////////
    // Shadow of the control word, rebuilt from the wire, and its age.
    // The age waits out the device's synchroniser so that checks see settled state.
    assign taken = sclk_q && !sclk && !frame_sync_n;
    assign word = {shift[14:0], sdata};
    assign age_ok = (age == 4'hf);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b1;
            shift <= 16'h0000;
            bit_count <= 5'h00;
            ctrl <= 14'h0000;
            age <= 4'h0;
        end else begin
            sclk_q <= sclk;
            bit_count <= frame_sync_n ? 5'h00 : bit_count + 5'(taken);
            if (taken) begin
                shift <= word;
            end
            if (taken && bit_count == 5'h0f && word[15:14] == 2'h0) begin
                ctrl <= word[13:0];
                age <= 4'h0;
            end else if (!age_ok) begin
                age <= age + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_frame_length: assert property ($rose(frame_sync_n) |-> bit_count == 5'h10)
        else $error("frame did not carry sixteen bits");
    a_sclk_idle: assert property (frame_sync_n && $past(frame_sync_n) |-> sclk)
        else $error("serial clock not high between frames");
    a_data_steady: assert property (taken |-> $stable(sdata))
        else $error("serial data moved at the falling clock");
    a_square_enable: assert property (age_ok |-> square_out_enable == ctrl[5])
        else $error("square enable differs from control bit");
    a_square_comparator: assert property (
        (age_ok && ctrl[5] && ctrl[4] && $stable(comparator_in)) [*6]
        |-> square_out == comparator_in)
        else $error("comparator not routed to square pin");
    a_dac_soft_down: assert property (age_ok && !ctrl[9] |-> dac_power_down == ctrl[6])
        else $error("DAC power state differs from control bit");
    a_dac_pin_down: assert property (
        (age_ok && ctrl[9] && $stable(sleep_pin)) [*6] |-> dac_power_down == sleep_pin)
        else $error("DAC power state differs from sleep pin");
    a_soft_reset_mid: assert property (
        age_ok && !ctrl[9] && ctrl[8] |-> dac_code == 10'h200)
        else $error("software reset left output off midscale");
    a_pin_reset_mid: assert property (
        (age_ok && ctrl[9] && reset_pin) [*6] |-> dac_code == 10'h200)
        else $error("reset pin left output off midscale");
    a_clock_freeze: assert property (
        age_ok && $past(age_ok) && !ctrl[9] && ctrl[7] && !ctrl[8] |-> $stable(dac_code))
        else $error("output moved while clock stopped");
    a_release_delay: assert property (
        $fell(reset_pin) && age_ok && ctrl[9] && ctrl[1] && !ctrl[7]
        |-> (dac_code == 10'h200) [*8] ##[1:8] dac_code != 10'h200)
        else $error("waveform start after reset off time");

    c_frame: cover property ($rose(frame_sync_n));
    c_pin_reset: cover property (age_ok && ctrl[9] && reset_pin);
    c_comparator: cover property (age_ok && ctrl[5] && ctrl[4]);
endmodule : dds_link_checker

// ==== test/tb_top.sv ====
/*
 * Self-checking bench: host and synthesizer ends joined by the link.
 * Assumes the control bit positions and pipeline of the shared package.
 */
`timescale 1ns/100ps
module tb_top;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [15:0] cmd_word = 16'h0000;
    logic cmd_ready;
    logic reset_request = 1'b0;
    logic sleep_request = 1'b0;
    logic freq_select = 1'b0;
    logic phase_select = 1'b0;
    logic comparator_in = 1'b0;
    logic [9:0] dac_code;
    logic dac_power_down;
    logic square_out;
    logic square_out_enable;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock, link and both ends.
    always #20 sys_clk = ~sys_clk;
    dds_link_if link ();
    dds_host dds_host_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(link.host),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
        .reset_request(reset_request), .sleep_request(sleep_request),
        .freq_select(freq_select), .phase_select(phase_select));
    dds_device dds_device_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(link.device),
        .comparator_in(comparator_in), .dac_code(dac_code),
        .dac_power_down(dac_power_down), .square_out(square_out),
        .square_out_enable(square_out_enable));
    dds_link_checker dds_link_checker_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .sclk(link.sclk), .sdata(link.sdata), .frame_sync_n(link.frame_sync_n),
        .reset_pin(link.reset_pin), .sleep_pin(link.sleep_pin),
        .comparator_in(comparator_in), .dac_code(dac_code),
        .dac_power_down(dac_power_down), .square_out(square_out),
        .square_out_enable(square_out_enable));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        total_checks++;
        if (seen !== expected) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // Triangle code for a held phase: the fold on the top phase bit.
    // The fold is done at ten bits so that the inversion stays inside the code.
    function automatic logic [15:0] tri_of(input logic [11:0] p);
        logic [9:0] t;
        t = p[11] ? ~p[10:1] : p[10:1];
        return {6'h00, t};
    endfunction : tri_of

    // One word through the host; the wait for ready is bounded so a hang is caught.
    task automatic send(input logic [15:0] word);
        int waited;
        cmd_word = word;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        @(negedge sys_clk);
        waited = 0;
        while (cmd_ready !== 1'b1 && waited < 300) begin
            @(negedge sys_clk);
            waited++;
        end
        check(16'(waited < 300), 16'h0001);
        repeat (16) @(negedge sys_clk);
    endtask : send

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic test_phase();
        send(16'hC400);
        check(16'(dac_code > 10'h380), 16'h0001);
        check(16'(dac_power_down), 16'h0000);
        send(16'hCC00);
        check(16'(dac_code < 10'h080), 16'h0001);
        send(16'hD100);
        send(16'hE900);
        send(16'h0002);
        check(16'(dac_code), tri_of(12'h100));
        send(16'h0402);
        check(16'(dac_code), tri_of(12'h900));
        send(16'h0202);
        phase_select = 1'b1;
        freq_select = 1'b1;
        repeat (8) @(negedge sys_clk);
        check(16'(dac_code), tri_of(12'h900));
        phase_select = 1'b0;
        freq_select = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(16'(dac_code), tri_of(12'h100));
    endtask : test_phase

    task automatic test_stop();
        send(16'h0082);
        send(16'hC500);
        check(16'(dac_code), tri_of(12'h100));
        send(16'h0002);
        check(16'(dac_code), tri_of(12'h500));
    endtask : test_stop

    task automatic test_reset();
        int n;
        reset_request = 1'b1;
        repeat (10) @(negedge sys_clk);
        check(16'(dac_code), tri_of(12'h500));
        send(16'h0202);
        check(16'(dac_code), 16'h0200);
        reset_request = 1'b0;
        n = 0;
        while (dac_code === 10'h200 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check(16'(n >= 9 && n <= 14), 16'h0001);
        check(16'(dac_code), tri_of(12'h500));
        send(16'h0102);
        check(16'(dac_code), 16'h0200);
    endtask : test_reset

    task automatic test_sleep();
        logic [15:0] ctl [6] = '{16'h0042, 16'h0002, 16'h00C2, 16'h0202, 16'h0242, 16'h0202};
        logic [5:0] pin = 6'b001010;
        logic [5:0] down = 6'b001101;
        for (int i = 0; i < 6; i++) begin
            sleep_request = pin[i];
            send(ctl[i]);
            check(16'(dac_power_down), 16'(down[i]));
        end
    endtask : test_sleep

    task automatic test_square();
        logic [15:0] ctl [6] = '{16'h0000, 16'h0038, 16'h0038, 16'h0028, 16'hC900, 16'h0028};
        logic [5:0] cmp = 6'b010011;
        logic [5:0] en = 6'b111110;
        logic [5:0] out = 6'b110010;
        for (int i = 0; i < 6; i++) begin
            comparator_in = cmp[i];
            send(ctl[i]);
            check(16'(square_out_enable), 16'(en[i]));
            check(16'(square_out), 16'(out[i]));
        end
    endtask : test_square

    // Square pin from the running phase MSB, at full rate and then halved.
    // Upper frequency half 0x400 gives an MSB period of sixteen cycles.
    task automatic test_msb();
        int rises;
        logic prev;
        send(16'h1028);
        for (int m = 0; m < 2; m++) begin
            send(m == 0 ? 16'h4400 : 16'h1020);
            rises = 0;
            prev = square_out;
            repeat (128) begin
                @(negedge sys_clk);
                rises += int'(square_out && !prev);
                prev = square_out;
            end
            check(16'(rises), m == 0 ? 16'h0008 : 16'h0004);
        end
    endtask : test_msb

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need about 4400 cycles, so 20000 means a hang.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // Main sequence: power-up reset, then each scenario in turn.
    initial begin
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        @(negedge sys_clk);
        test_phase();
        test_stop();
        test_reset();
        test_sleep();
        test_square();
        test_msb();
        tally_and_finish();
    end
endmodule : tb_top
